// *** src/pll_clock_pkg.sv ***
package pll_clock_pkg;

  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;

  localparam logic [3:0] OFS_MULT_CTRL  = 4'h0;
  localparam logic [3:0] OFS_STATUS     = 4'h1;
  localparam logic [3:0] OFS_CLKOUT_CFG = 4'h2;

  localparam int unsigned MULT_W   = 4;
  localparam logic [3:0]  MULT_RST = 4'h0;
  localparam logic [3:0]  MULT_MAX = 4'ha;

  localparam int unsigned STS_LOCK_BIT   = 0;
  localparam int unsigned STS_DIVSEL_BIT = 1;
  localparam int unsigned STS_MISS_BIT   = 3;
  localparam int unsigned STS_CLEAR_BIT  = 4;

  localparam logic DIVSEL_RST = 1'b0;
  localparam logic LOCK_RST   = 1'b0;
  localparam logic MISS_RST   = 1'b0;

  localparam logic [1:0] CLKOUT_DIV4  = 2'h0;
  localparam logic [1:0] CLKOUT_DIV2  = 2'h1;
  localparam logic [1:0] CLKOUT_DIV1  = 2'h2;
  localparam logic [1:0] CLKOUT_OFF   = 2'h3;
  localparam logic [1:0] CLKOUT_RST   = CLKOUT_DIV4;

  localparam int unsigned OSC_CNT_W = 7;
  localparam int unsigned VCO_CNT_W = 13;

  typedef enum logic [1:0] {
    SRC_OSC  = 2'b00,
    SRC_PLL  = 2'b01,
    SRC_LIMP = 2'b10,
    SRC_STOP = 2'b11
  } clk_src_type;

  typedef enum logic [1:0] {
    LK_BYPASS  = 2'b00,
    LK_WAIT    = 2'b01,
    LK_RUNNING = 2'b10
  } lock_state_type;

endpackage

// *** src/det_counter.sv ***
`timescale 1ns/1ps
module det_counter #(
  parameter int unsigned W = 7
) (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic clr,
  input  wire logic inc,
  output logic      ovf
);

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  wire          at_top = &cnt_q;

  assign cnt_d = clr ? '0 : (inc ? cnt_q + 1'b1 : cnt_q);
  assign ovf   = inc & at_top & ~clr;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

endmodule

// *** src/pll_clock_ctrl.sv ***
// Function
// [RULE_01] Multiplier zero bypasses PLL; CPU clock is oscillator or half, per divide-select.
// [RULE_02] Bypass: missing oscillator switches to limp, sets status, pulses internal reset.
// [RULE_03] Nonzero multiplier n enables PLL; CPU clock is oscillator times n, optionally halved.
// [RULE_04] PLL mode: missing oscillator sets status, resets, runs at half limp.
// [RULE_05] Standby stops CPU clock; detection still sets status, resets, routes limp clock.
// [RULE_06] Halt stops all clocks; detection counters run only after power-up completes.
// [RULE_07] After halt, PLL-side counter overflow sets status, resets, routes limp clock.
// [RULE_08] Clock-out is system clock divided by one, two or four per divide field.
// [RULE_09] Clock-out defaults to a quarter of the system clock at power-up.
// [RULE_10] Clock-out keeps toggling at a quarter of system clock during reset.
// [RULE_11] Clock-out divide field with both bits set turns clock-out off.
// [RULE_12] Software keeps divide-select zero while writing multiplier until lock reads one.
// [RULE_13] Software writes the multiplier only while missing-clock status reads zero.
// [RULE_14] Multiplier write runs CPU at half oscillator until lock, then new frequency.
// [RULE_15] Lock-complete flag sets when the switch to the new frequency happens.
// [RULE_16] Multiplier codes: zero bypass, one to ten multiply, eleven to fifteen reserved.
// [RULE_17] Multiplier resets to zero, so CPU starts at half oscillator clock.
// [RULE_18] Multiplier register takes writes only while protected write enable is open.
// [RULE_19] Control and status reset only by pin reset or watchdog reset.
// [RULE_20] System clock output runs at the same rate as CPU input clock.
// [RULE_21] Seven-bit oscillator counter overflow clears thirteen-bit PLL counter; its overflow detects.
// [RULE_22] Writing clear bit clears missing status and detection counters; detection repeats.
// [RULE_23] Missing-clock reset is internal and never drives the external reset pin.
// [RULE_24] Every CPU clock source switch is glitch-free with no runt pulses.
`timescale 1ns/1ps
module pll_clock_ctrl
  import pll_clock_pkg::*;
(
  input  wire logic                          clk_sys,
  input  wire logic                          por_n,
  input  wire logic                          rst_n,
  input  wire logic                          watchdog_reset,
  input  wire logic [pll_clock_pkg::ADDR_W-1:0] addr,
  input  wire logic [pll_clock_pkg::DATA_W-1:0] wdata,
  input  wire logic                          wr,
  input  wire logic                          rd,
  output logic      [pll_clock_pkg::DATA_W-1:0] rdata,
  input  wire logic                          protected_write_enable,
  input  wire logic                          oscillator_tick,
  input  wire logic                          pll_vco_tick,
  input  wire logic                          pll_out_tick,
  input  wire logic                          limp_tick,
  input  wire logic                          pll_locked,
  input  wire logic                          standby_mode,
  input  wire logic                          halt_mode,
  input  wire logic                          power_up_done,
  output logic                               pll_enable,
  output logic      [pll_clock_pkg::MULT_W-1:0] pll_multiplier,
  output logic                               cpu_clock_tick,
  output logic                               system_clock_output,
  output logic                               external_clock_out,
  output logic                               missing_clock_reset
);

  import pll_clock_pkg::*;

  logic [MULT_W-1:0] mult_q;
  logic [MULT_W-1:0] mult_d;
  logic              divsel_q;
  logic              divsel_d;
  logic              lock_flag_q;
  logic              lock_flag_d;
  logic              miss_q;
  logic              miss_d;
  logic [1:0]        clkout_div_q;
  logic [1:0]        clkout_div_d;
  lock_state_type    lock_st_q;
  lock_state_type    lock_st_d;
  clk_src_type       cur_src_q;
  clk_src_type       cur_src_d;
  logic              cur_half_q;
  logic              cur_half_d;
  logic              phase_q;
  logic              phase_d;
  logic [1:0]        xdiv_q;
  logic [1:0]        xdiv_d;
  logic              xout_q;
  logic              xout_d;
  logic              mreset_q;
  logic [DATA_W-1:0] rdata_q;
  logic [DATA_W-1:0] rdata_d;

  // The pin reset and the watchdog reset are the only sources that reload the control
  // state; the missing-clock reset is deliberately kept out of this term.
  wire ctl_clear = watchdog_reset; // see [RULE_19]

  wire sel_mult   = addr == OFS_MULT_CTRL;
  wire sel_status = addr == OFS_STATUS;
  wire sel_clkout = addr == OFS_CLKOUT_CFG;

  wire wr_mult_hit = wr & sel_mult & protected_write_enable; // see [RULE_18]
  wire mult_legal  = wdata[MULT_W-1:0] <= MULT_MAX; // see [RULE_16]
  wire wr_mult     = wr_mult_hit & mult_legal;
  wire wr_status   = wr & sel_status;
  wire wr_clkout   = wr & sel_clkout;
  wire miss_clear  = wr_status & wdata[STS_CLEAR_BIT]; // see [RULE_22]

  // Detection runs only once oscillator and PLL have powered up after halt, and
  // stays frozen while a missing clock is already latched.
  wire det_run = ~halt_mode & power_up_done & ~miss_q; // see [RULE_06]
  wire osc_ovf;
  wire vco_ovf;

  det_counter #(
    .W (OSC_CNT_W)
  ) u_osc_cnt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (miss_clear | ~det_run),
    .inc     (oscillator_tick),
    .ovf     (osc_ovf)
  );

  det_counter #(
    .W (VCO_CNT_W)
  ) u_vco_cnt (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clr     (miss_clear | ~det_run | osc_ovf), // see [RULE_21]
    .inc     (pll_vco_tick),
    .ovf     (vco_ovf)
  );

  wire miss_detect = vco_ovf & det_run; // see [RULE_07]

  assign mult_d   = wr_mult ? wdata[MULT_W-1:0] : mult_q;
  assign divsel_d = wr_status ? wdata[STS_DIVSEL_BIT] : divsel_q;

  // A software clear masks the counter overflow in its own cycle, so the clear wins and detection restarts.
  assign miss_d = miss_detect | (miss_q & ~miss_clear); // see [RULE_02]

  assign clkout_div_d = wr_clkout ? wdata[1:0] : clkout_div_q;

  always_comb
  begin
    lock_st_d   = lock_st_q;
    lock_flag_d = lock_flag_q;
    unique case (lock_st_q)
      LK_BYPASS, LK_RUNNING:
      begin
        if (wr_mult)
        begin
          lock_st_d   = LK_WAIT; // see [RULE_14]
          lock_flag_d = 1'b0;
        end
      end
      LK_WAIT:
      begin
        if (wr_mult)
          lock_flag_d = 1'b0;
        else if (mult_q == MULT_RST)
        begin
          lock_st_d   = LK_BYPASS;
          lock_flag_d = 1'b1; // see [RULE_15]
        end
        else if (pll_locked)
        begin
          lock_st_d   = LK_RUNNING;
          lock_flag_d = 1'b1; // see [RULE_15]
        end
      end
      default:
      begin
        lock_st_d   = LK_BYPASS;
        lock_flag_d = 1'b0;
      end
    endcase
  end

  // Wanted source and halving, before the glitch-free handover.
  clk_src_type want_src;
  logic        want_half;

  always_comb
  begin
    want_src  = SRC_OSC;
    want_half = ~divsel_q; // see [RULE_01]
    if (halt_mode)
      want_src = SRC_STOP; // see [RULE_06]
    else if (miss_q)
    begin
      want_src  = SRC_LIMP;
      want_half = (mult_q != MULT_RST) | ~divsel_q; // see [RULE_04]
    end
    else if (standby_mode)
      want_src = SRC_STOP; // see [RULE_05]
    else if (lock_st_q == LK_WAIT)
    begin
      want_src  = SRC_OSC;
      want_half = 1'b1; // see [RULE_14]
    end
    else if (mult_q != MULT_RST)
      want_src = SRC_PLL; // see [RULE_03]
  end

  wire src_tick = (cur_src_q == SRC_OSC)  ? oscillator_tick :
                  (cur_src_q == SRC_PLL)  ? pll_out_tick :
                  (cur_src_q == SRC_LIMP) ? limp_tick : 1'b0;

  // A new source is taken only between whole output periods, so the CPU never sees a
  // shortened period. A failed oscillator may freeze the phase, so the cycle in which
  // limp is first wanted forces the handover; the dead source cannot make a runt.
  wire at_boundary = ~phase_q | mreset_q; // see [RULE_24]
  wire swap = at_boundary & ((want_src != cur_src_q) | (want_half != cur_half_q));

  assign cur_src_d  = swap ? want_src : cur_src_q; // see [RULE_24]
  assign cur_half_d = swap ? want_half : cur_half_q;
  assign phase_d    = swap ? 1'b0 : ((src_tick & cur_half_q) ? ~phase_q : phase_q);

  // Stopping only stretches a period, so a stop request gates the tick at once.
  wire stop_now = want_src == SRC_STOP; // see [RULE_05]
  wire cpu_tick = src_tick & ~swap & ~stop_now & (~cur_half_q | phase_q); // see [RULE_06]

  assign cpu_clock_tick      = cpu_tick;
  assign system_clock_output = cpu_tick; // see [RULE_20]

  // The clock-out divider runs on the power-on reset only, so it keeps running while
  // the pin reset is low; the field then reads as its quarter-rate default.
  wire [1:0] xsel = rst_n ? clkout_div_q : CLKOUT_RST; // see [RULE_10]

  always_comb
  begin
    xdiv_d = xdiv_q;
    xout_d = xout_q;
    unique case (xsel)
      CLKOUT_DIV1:
      begin
        if (cpu_tick)
          xout_d = ~xout_q; // see [RULE_08]
      end
      CLKOUT_DIV2:
      begin
        if (cpu_tick)
        begin
          xdiv_d = {1'b0, ~xdiv_q[0]};
          if (xdiv_q[0])
            xout_d = ~xout_q; // see [RULE_08]
        end
      end
      CLKOUT_DIV4:
      begin
        if (cpu_tick)
        begin
          xdiv_d = xdiv_q + 2'h1;
          if (xdiv_q == 2'h3)
            xout_d = ~xout_q; // see [RULE_09]
        end
      end
      CLKOUT_OFF:
      begin
        xdiv_d = 2'h0;
        xout_d = 1'b0; // see [RULE_11]
      end
    endcase
  end

  assign external_clock_out = xout_q;

  // This pulse is the block's own reset request; it is not routed to the reset pin.
  assign missing_clock_reset = mreset_q; // see [RULE_23]

  assign pll_enable     = mult_q != MULT_RST; // see [RULE_03]
  assign pll_multiplier = mult_q;

  always_comb
  begin
    rdata_d = '0;
    if (rd & sel_mult)
      rdata_d[MULT_W-1:0] = mult_q;
    else if (rd & sel_status)
    begin
      rdata_d[STS_LOCK_BIT]   = lock_flag_q;
      rdata_d[STS_DIVSEL_BIT] = divsel_q;
      rdata_d[STS_MISS_BIT]   = miss_q;
    end
    else if (rd & sel_clkout)
      rdata_d[1:0] = clkout_div_q;
  end

  assign rdata = rdata_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mult_q       <= MULT_RST; // see [RULE_17]
      divsel_q     <= DIVSEL_RST;
      lock_flag_q  <= LOCK_RST;
      miss_q       <= MISS_RST;
      clkout_div_q <= CLKOUT_RST;
      lock_st_q    <= LK_BYPASS;
    end
    else if (ctl_clear)
    begin
      mult_q       <= MULT_RST;
      divsel_q     <= DIVSEL_RST;
      lock_flag_q  <= LOCK_RST;
      miss_q       <= MISS_RST;
      clkout_div_q <= CLKOUT_RST;
      lock_st_q    <= LK_BYPASS;
    end
    else
    begin
      mult_q       <= mult_d;
      divsel_q     <= divsel_d;
      lock_flag_q  <= lock_flag_d;
      miss_q       <= miss_d;
      clkout_div_q <= clkout_div_d;
      lock_st_q    <= lock_st_d;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mreset_q <= 1'b0;
      rdata_q  <= '0;
    end
    else
    begin
      mreset_q <= miss_detect; // see [RULE_02]
      rdata_q  <= rdata_d;
    end
  end

  always_ff @(posedge clk_sys or negedge por_n)
  begin
    if (!por_n)
    begin
      cur_src_q  <= SRC_OSC;
      cur_half_q <= 1'b1;
      phase_q    <= 1'b0;
      xdiv_q     <= 2'h0;
      xout_q     <= 1'b0;
    end
    else
    begin
      cur_src_q  <= cur_src_d;
      cur_half_q <= cur_half_d;
      phase_q    <= phase_d;
      xdiv_q     <= xdiv_d;
      xout_q     <= xout_d;
    end
  end

endmodule

// *** dv/pll_clock_monitor.sv ***
`timescale 1ns/1ps
module pll_clock_monitor
  import pll_clock_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        por_n,
  input wire logic        rst_n,
  input wire logic        watchdog_reset,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        protected_write_enable,
  input wire logic        halt_mode,
  input wire logic        pll_enable,
  input wire logic [3:0]  pll_multiplier,
  input wire logic        cpu_clock_tick,
  input wire logic        system_clock_output,
  input wire logic        missing_clock_reset
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n || !por_n);
  sys_same_a: assert property (system_clock_output == cpu_clock_tick)
    else $error("system clock output differs");
  pll_on_a: assert property (pll_enable == (pll_multiplier != 4'h0))
    else $error("pll enable wrong");
  mult_range_a: assert property (pll_multiplier <= MULT_MAX)
    else $error("multiplier out of range");
  mult_block_a: assert property (wr && addr == OFS_MULT_CTRL
    && !protected_write_enable && !watchdog_reset |=> $stable(pll_multiplier))
    else $error("blocked write changed multiplier");
  mult_take_a: assert property (wr && addr == OFS_MULT_CTRL
    && protected_write_enable && !watchdog_reset && wdata <= 16'ha
    |=> 16'(pll_multiplier) == $past(wdata)) else $error("multiplier write lost");
  rd_idle_a: assert property (!rd |=> rdata == 16'h0)
    else $error("read data outside read slot");
  mreset_one_a: assert property (missing_clock_reset |=> !missing_clock_reset)
    else $error("missing clock reset too long");
  mreset_keep_a: assert property (missing_clock_reset && !wr
    && !watchdog_reset |=> $stable(pll_multiplier)) else $error("reset hit multiplier");
  wd_default_a: assert property (watchdog_reset |=> pll_multiplier == MULT_RST)
    else $error("watchdog did not reload");
  halt_stop_a: assert property (halt_mode |-> !cpu_clock_tick)
    else $error("cpu clock runs in halt");
endmodule
bind pll_clock_ctrl pll_clock_monitor pll_clock_monitor_i (.*);

// *** dv/osc_partner_model.sv ***
`timescale 1ns/1ps
module osc_partner_model #(
  parameter int OSC_P  = 4,
  parameter int LIMP_P = 3,
  parameter int LOCK_D = 60
) (
  input  wire logic       clk_sys,
  input  wire logic       osc_on,
  input  wire logic [3:0] pll_multiplier,
  output logic            oscillator_tick,
  output logic            pll_vco_tick,
  output logic            pll_out_tick,
  output logic            limp_tick,
  output logic            pll_locked
);
  int         oc = 0;
  int         lc = 0;
  int         lk = 0;
  logic [3:0] m_q = 4'h0;
  // The VCO keeps running when the oscillator is lost, so detection can fire.
  assign pll_vco_tick = 1'b1;
  assign oscillator_tick = osc_on && (oc == 0);
  assign pll_out_tick = osc_on && oc[0];
  assign limp_tick = (lc == 0);
  // Lock drops in the same cycle as a new multiplier, never one late.
  assign pll_locked = osc_on && (lk >= LOCK_D) && (m_q == pll_multiplier);
  always @(posedge clk_sys)
  begin
    oc <= (oc + 1) % OSC_P;
    lc <= (lc + 1) % LIMP_P;
    m_q <= pll_multiplier;
    lk <= (m_q != pll_multiplier) ? 0 : lk + (lk < LOCK_D);
  end
endmodule

// *** dv/pll_clock_ctrl_bench.sv ***
`timescale 1ns/1ps
module pll_clock_ctrl_bench;
  import pll_clock_pkg::*;
  logic        clk_sys = 1'b0, por_n = 1'b0, rst_n = 1'b0, watchdog_reset = 1'b0;
  logic        wr = 1'b0, rd = 1'b0, rd_q = 1'b0, protected_write_enable = 1'b1;
  logic        osc_on = 1'b1, standby_mode = 1'b0, halt_mode = 1'b0, power_up_done = 1'b1;
  logic [3:0]  addr = 4'h0, pll_multiplier;
  logic [15:0] wdata = 16'h0, rdata, m, q[$];
  logic        oscillator_tick, pll_vco_tick, pll_out_tick, limp_tick, pll_locked;
  logic        pll_enable, cpu_clock_tick, system_clock_output, external_clock_out;
  logic        missing_clock_reset;
  int          n_mismatch = 0, samples_checked = 0, seed = 71, c;

  pll_clock_ctrl pll_clock_ctrl_i (.*);
  osc_partner_model osc_partner_model_i (.*);
  always #12.5 clk_sys = ~clk_sys;

  task automatic print_verdict;
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string s, logic [15:0] seen, logic [15:0] e);
    samples_checked++;
    if (seen !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", s, e, seen);
    end
  endtask
  task automatic wreg(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [3:0] a, logic [15:0] e);
    @(posedge clk_sys);
    q.push_back(e);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
  endtask
  always @(posedge clk_sys)
  begin
    if (rd_q)
      chk("rdata", rdata, q.pop_front());
    rd_q <= rd;
  end
  task automatic wsig(int sel);
    c = 0;
    do
    begin
      @(posedge clk_sys);
      c++;
    end
    while ((sel == 0 ? missing_clock_reset : sel == 1 ? pll_locked : cpu_clock_tick)
      !== 1'b1 && c < 9999);
    if (c >= 9999)
    begin
      n_mismatch++;
      print_verdict();
    end
  endtask
  // The first gap after a source switch may be short, so only the last counts.
  task automatic per(int e);
    repeat (3) wsig(2);
    chk("tick period", 16'(c), 16'(e));
  endtask
  task automatic outdiv(int e);
    logic v;
    int   k;
    repeat (2)
    begin
      v = external_clock_out;
      k = 0;
      while (external_clock_out === v && k < 99)
      begin
        wsig(2);
        k++;
      end
      if (k >= 99)
      begin
        n_mismatch++;
        print_verdict();
      end
    end
    chk("clkout ticks", 16'(k), 16'(e));
  endtask
  task automatic quiet(bit s);
    repeat (2) @(posedge clk_sys);
    c = 0;
    repeat (64)
    begin
      @(posedge clk_sys);
      c += ((s ? external_clock_out : cpu_clock_tick) !== 1'b0);
    end
  endtask

  initial
  begin
    repeat (10) @(posedge clk_sys);
    por_n <= 1'b1;
    outdiv(4);
    rst_n <= 1'b1;
    rreg(OFS_MULT_CTRL, 16'h0);
    rreg(OFS_STATUS, 16'h0);
    rreg(OFS_CLKOUT_CFG, 16'h0);
    rreg(4'hf, 16'h0);
    per(8);
    for (int d = 0; d < 3; d++)
    begin
      wreg(OFS_CLKOUT_CFG, 16'(d));
      outdiv(4 >> d);
    end
    wreg(OFS_CLKOUT_CFG, 16'(CLKOUT_OFF));
    quiet(1'b1);
    chk("clkout off", 16'(c), 16'h0);
    wreg(OFS_CLKOUT_CFG, 16'h0);
    wreg(OFS_STATUS, 16'h2);
    per(4);
    wreg(OFS_STATUS, 16'h0);
    m = 16'(1 + $unsigned($random(seed)) % 10);
    protected_write_enable <= 1'b0;
    wreg(OFS_MULT_CTRL, m);
    rreg(OFS_MULT_CTRL, 16'h0);
    protected_write_enable <= 1'b1;
    wreg(OFS_MULT_CTRL, 16'hb);
    rreg(OFS_MULT_CTRL, 16'h0);
    wreg(OFS_MULT_CTRL, m);
    rreg(OFS_STATUS, 16'h0);
    per(8);
    wsig(1);
    repeat (8) @(posedge clk_sys);
    rreg(OFS_STATUS, 16'h1);
    per(4);
    wreg(OFS_STATUS, 16'h2);
    per(2);
    osc_on <= 1'b0;
    wsig(0);
    per(6);
    rreg(OFS_STATUS, 16'hb);
    rreg(OFS_MULT_CTRL, m);
    osc_on <= 1'b1;
    wreg(OFS_STATUS, 16'h12);
    rreg(OFS_STATUS, 16'h3);
    watchdog_reset <= 1'b1;
    @(posedge clk_sys);
    watchdog_reset <= 1'b0;
    rreg(OFS_MULT_CTRL, 16'h0);
    rreg(OFS_STATUS, 16'h0);
    wreg(OFS_STATUS, 16'h2);
    osc_on <= 1'b0;
    wsig(0);
    per(3);
    rreg(OFS_STATUS, 16'ha);
    osc_on <= 1'b1;
    wreg(OFS_STATUS, 16'h10);
    rreg(OFS_STATUS, 16'h0);
    standby_mode <= 1'b1;
    quiet(1'b0);
    chk("standby ticks", 16'(c), 16'h0);
    standby_mode <= 1'b0;
    halt_mode <= 1'b1;
    power_up_done <= 1'b0;
    quiet(1'b0);
    chk("halt ticks", 16'(c), 16'h0);
    halt_mode <= 1'b0;
    power_up_done <= 1'b1;
    per(8);
    print_verdict();
  end
endmodule
